// ===== hdl/dsc_deser_ctrl.sv
// Purpose: receiver feature register, lock and payload delivery
// Assumes: register port already decoded from the serial control bus
// Notes: analog equalizer and clock spreading sit outside; this block
//        only drives their settings and the modulation rate tick
// How it works
// - gain field bits 7:5, eight steps
// - bit 4 switches the equalizer on
// - normal mode spread decode, 2168 or 1300
// - low frequency decode, 625 or 385
// - 24 color, sync and enable bits delivered
// - 18-bit use passes general purpose bits
// - lock on live random data, no pattern
// - register settings apply only when selected
`timescale 1ns/1ns
module dsc_deser_ctrl #(
  parameter int LOCK_WORDS = dsc_pkg::LOCK_WORDS,
  parameter int FIFO_DEPTH = dsc_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // control and strap pins
  input wire logic [2:0] strapEqGain,
  input wire logic strapEqOn,
  input wire logic [2:0] strapSsc,
  input wire logic lowFreqSelect,
  input wire logic colorDepth18,
  // link side
  input wire logic [dsc_pkg::WORD_W-1:0] linkWord,
  input wire logic linkValid,
  input wire logic linkCodeErr,
  output logic linkReady,
  // display side
  output logic [dsc_pkg::COLOR_W-1:0] dispColor,
  output logic dispHsync,
  output logic dispVsync,
  output logic dispDataEn,
  output logic [dsc_pkg::GP_W-1:0] dispGp,
  output logic dispValid,
  input wire logic dispReady,
  // equalizer and spread clock settings, lock status
  output logic [2:0] equalizerGain,
  output logic equalizerOn,
  output logic sscActive,
  output logic [dsc_pkg::DIV_W-1:0] sscModDiv,
  output logic sscModTick,
  output logic rxLocked
);

  typedef enum logic {DSC_ACQUIRE, DSC_LOCKED} dsc_lock_t;

  logic [7:0] feat2_q, feat2_d;
  logic regSrc_q, regSrc_d;
  logic [7:0] rdData_q, rdData_d;
  logic [2:0] sscSel;
  logic [dsc_pkg::DIV_W-1:0] modCnt_q, modCnt_d;
  logic tick_q, tick_d;
  dsc_lock_t lock_q, lock_d;
  logic [15:0] goodCnt_q, goodCnt_d;
  logic goodWord, fifoInReady, fifoInValid;
  logic [dsc_pkg::WORD_W-1:0] headWord;

  function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
    hits = (a == off);
  endfunction : hits

  // modulation divider picked by code and frequency mode
  function automatic logic [11:0] modDivide(input logic [2:0] code,
                                            input logic lf);
    if (lf) begin
      modDivide = (code >= dsc_pkg::SSC_HI_RATE_FIRST) ?
        dsc_pkg::DIV_LF_HI : dsc_pkg::DIV_LF_LO;
    end else begin
      modDivide = (code >= dsc_pkg::SSC_HI_RATE_FIRST) ?
        dsc_pkg::DIV_NORM_HI : dsc_pkg::DIV_NORM_LO;
    end
  endfunction : modDivide

  // register writes and registered read data
  always_comb begin
    feat2_d = feat2_q;
    regSrc_d = regSrc_q;
    rdData_d = rdData_q;
    if (regWrEn && hits(regAddr, dsc_pkg::REG_FEAT2)) begin
      feat2_d = regWrData;
    end
    if (regWrEn && hits(regAddr, dsc_pkg::REG_CFG1)) begin
      regSrc_d = regWrData[dsc_pkg::CFG1_REGSRC_BIT];
    end
    if (regRdEn) begin
      if (hits(regAddr, dsc_pkg::REG_FEAT2)) begin
        rdData_d = feat2_q;
      end else if (hits(regAddr, dsc_pkg::REG_CFG1)) begin
        rdData_d = {7'h00, regSrc_q};
      end else begin
        rdData_d = 8'h00; // unmapped reads as zero
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      feat2_q <= dsc_pkg::FEAT2_RESET;
      regSrc_q <= dsc_pkg::CFG1_RESET[dsc_pkg::CFG1_REGSRC_BIT];
      rdData_q <= 8'h00;
    end else if (clkEn) begin
      feat2_q <= feat2_d;
      regSrc_q <= regSrc_d;
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

  // pins rule until software hands control to the registers
  always_comb begin
    if (regSrc_q) begin
      equalizerGain = feat2_q[dsc_pkg::GAIN_MSB:dsc_pkg::GAIN_LSB];
      equalizerOn = feat2_q[dsc_pkg::EQON_BIT];
      sscSel = feat2_q[dsc_pkg::SSC_MSB:dsc_pkg::SSC_LSB];
    end else begin
      equalizerGain = strapEqGain;
      equalizerOn = strapEqOn;
      sscSel = strapSsc;
    end
  end

  assign sscActive = (sscSel != dsc_pkg::SSC_OFF);
  assign sscModDiv = modDivide(sscSel, lowFreqSelect);

  // modulation rate tick; restarts when spreading is off
  always_comb begin
    modCnt_d = modCnt_q;
    tick_d = 1'b0;
    if (!sscActive) begin
      modCnt_d = '0;
    end else if (modCnt_q >= sscModDiv - 1'b1) begin
      modCnt_d = '0;
      tick_d = 1'b1;
    end else begin
      modCnt_d = modCnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      modCnt_q <= '0;
      tick_q <= 1'b0;
    end else if (clkEn) begin
      modCnt_q <= modCnt_d;
      tick_q <= tick_d;
    end
  end

  assign sscModTick = tick_q;

  // lock: a run of clean words, no training pattern needed
  assign goodWord = linkValid && !linkCodeErr;

  always_comb begin
    lock_d = lock_q;
    goodCnt_d = goodCnt_q;
    unique case (lock_q)
      DSC_ACQUIRE: begin
        if (linkCodeErr) begin
          goodCnt_d = '0;
        end else if (goodWord) begin
          if (goodCnt_q == 16'(LOCK_WORDS - 1)) begin
            lock_d = DSC_LOCKED;
            goodCnt_d = '0;
          end else begin
            goodCnt_d = goodCnt_q + 1'b1;
          end
        end
      end
      DSC_LOCKED: begin
        if (linkCodeErr) begin
          lock_d = DSC_ACQUIRE; // drop lock, hunt again
          goodCnt_d = '0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_q <= DSC_ACQUIRE;
      goodCnt_q <= '0;
    end else if (clkEn) begin
      lock_q <= lock_d;
      goodCnt_q <= goodCnt_d;
    end
  end

  assign rxLocked = (lock_q == DSC_LOCKED);

  // words are drained while hunting so a live stream never stalls
  assign fifoInValid = rxLocked && goodWord;
  assign linkReady = rxLocked ? fifoInReady : 1'b1;

  dsc_fifo #(
    .WIDTH(dsc_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .ce(clkEn),
    .inData(linkWord),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .outData(headWord),
    .outValid(dispValid),
    .outReady(dispReady)
  );

  // color bits go out untouched; their order is the host's business
  assign dispColor = headWord[dsc_pkg::COLOR_W-1:0];
  assign dispHsync = headWord[dsc_pkg::HSYNC_BIT];
  assign dispVsync = headWord[dsc_pkg::VSYNC_BIT];
  assign dispDataEn = headWord[dsc_pkg::DATAEN_BIT];
  // in 18-bit use the two low bits of each color are spare
  assign dispGp = colorDepth18 ? {
    headWord[dsc_pkg::RED_LSB+1:dsc_pkg::RED_LSB],
    headWord[dsc_pkg::GREEN_LSB+1:dsc_pkg::GREEN_LSB],
    headWord[dsc_pkg::BLUE_LSB+1:dsc_pkg::BLUE_LSB]} : 6'h00;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence feat2Write;
    clkEn && regWrEn && hits(regAddr, dsc_pkg::REG_FEAT2);
  endsequence

  sequence regSrcHeld;
    clkEn && regSrc_q && !(regWrEn && hits(regAddr, dsc_pkg::REG_CFG1));
  endsequence

  sequence lastClean;
    clkEn && !rxLocked && goodWord && goodCnt_q == 16'(LOCK_WORDS - 1);
  endsequence

  gain_field_a: assert property (
    feat2Write ##0 regSrcHeld |=> equalizerGain == $past(regWrData[7:5]))
    else $error("equalizer gain not taken from register write");

  equalizer_on_a: assert property (
    feat2Write ##0 regSrcHeld |=> equalizerOn == $past(regWrData[4]))
    else $error("equalizer enable not taken from register write");

  ssc_normal_a: assert property (
    !lowFreqSelect && sscSel inside {[3'h1:3'h4]}
      |-> sscActive && sscModDiv == 12'h0878)
    else $error("normal mode low codes not at clk/2168");

  ssc_fast_a: assert property (
    !lowFreqSelect && sscSel >= 3'h5 |-> sscModDiv == 12'h0514)
    else $error("normal mode high codes not at clk/1300");

  ssc_off_a: assert property (
    clkEn && sscSel == 3'h0 |=> !sscModTick)
    else $error("modulation tick while spreading is off");

  ssc_lowfreq_a: assert property (
    lowFreqSelect && sscSel != 3'h0 |->
      sscModDiv == ((sscSel >= 3'h5) ? 12'h0181 : 12'h0271))
    else $error("low frequency decode wrong");

  lock_entry_a: assert property (
    lastClean ##0 !linkCodeErr |=> rxLocked)
    else $error("no lock after a full run of clean words");

  lock_early_a: assert property (
    $rose(rxLocked) |-> $past(goodCnt_q) == 16'(LOCK_WORDS - 1))
    else $error("lock taken before the run was complete");

  pass_word_a: assert property (
    clkEn && fifoInValid && fifoInReady && !dispValid |=>
      dispValid && dispColor == $past(linkWord[23:0])
      && dispDataEn == $past(linkWord[26]))
    else $error("pixel word not delivered to display side");

  gp_bits_a: assert property (
    colorDepth18 && dispValid |-> dispGp == {dispColor[17:16],
      dispColor[9:8], dispColor[1:0]})
    else $error("general purpose bits not delivered");

  strap_rule_a: assert property (
    !regSrc_q |-> equalizerGain == strapEqGain && equalizerOn == strapEqOn)
    else $error("registers steer equalizer while pins selected");

  rsvd_read_a: assert property (
    feat2Write ##1 !regWrEn ##1 clkEn && regRdEn
      && hits(regAddr, dsc_pkg::REG_FEAT2) && !regWrEn
      |=> regRdData[3] == $past(regWrData[3], 3))
    else $error("reserved bit not read back as written");

endmodule : dsc_deser_ctrl

// ===== hdl/dsc_fifo.sv
// Purpose: small flop-based FIFO between link and display side
// Assumes: single clock, synchronous active-high reset
// Notes: inReady is low only when full, outValid low only when empty
`timescale 1ns/1ns
module dsc_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // fill side
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // drain side
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [CW-1:0] count_q, count_d;
  logic push, pop;

  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nextPtr

  // honest flags straight from the occupancy count
  assign inReady = (count_q != CW'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // next pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (push) begin
      mem_d[wrPtr_q] = inData;
      wrPtr_d = nextPtr(wrPtr_q);
    end
    if (pop) begin
      rdPtr_d = nextPtr(rdPtr_q);
    end
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // storage needs no reset, only the bookkeeping does
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else if (ce) begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      mem_q <= mem_d;
    end
  end

endmodule : dsc_fifo

// ===== hdl/dsc_pkg.sv
// Purpose: shared constants for the receiver feature and payload block
// Assumes: byte-wide register port, 27-bit parallel link word
// Notes: offsets are register indices on the serial control bus
package dsc_pkg;

  // register map
  localparam logic [7:0] REG_CFG1 = 8'h00;
  localparam logic [7:0] REG_FEAT2 = 8'h03;
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [7:0] FEAT2_RESET = 8'h00;
  localparam int CFG1_REGSRC_BIT = 0;

  // second feature register fields
  localparam int GAIN_MSB = 7;
  localparam int GAIN_LSB = 5;
  localparam int EQON_BIT = 4;
  localparam int RSVD_BIT = 3;
  localparam int SSC_MSB = 2;
  localparam int SSC_LSB = 0;
  localparam logic [2:0] SSC_OFF = 3'h0;
  localparam logic [2:0] SSC_HI_RATE_FIRST = 3'h5;

  // modulation rate dividers of the output clock
  localparam int DIV_W = 12;
  localparam logic [11:0] DIV_NORM_LO = 12'h0878; // clk/2168
  localparam logic [11:0] DIV_NORM_HI = 12'h0514; // clk/1300
  localparam logic [11:0] DIV_LF_LO = 12'h0271; // clk/625
  localparam logic [11:0] DIV_LF_HI = 12'h0181; // clk/385

  // link word layout: 24 color bits then hsync, vsync and data enable
  localparam int WORD_W = 27;
  localparam int COLOR_W = 24;
  localparam int HSYNC_BIT = 24;
  localparam int VSYNC_BIT = 25;
  localparam int DATAEN_BIT = 26;
  localparam int RED_LSB = 16;
  localparam int GREEN_LSB = 8;
  localparam int BLUE_LSB = 0;
  localparam int GP_W = 6;

  // lock acquisition and buffering
  localparam int LOCK_WORDS = 64;
  localparam int FIFO_DEPTH = 8;

endpackage : dsc_pkg

// ===== testbench/dsc_link_src.sv
// Purpose: link source model standing in for the remote serializer
// Assumes: a word is held until linkReady is seen high at a falling edge
// Notes: a released word shows the inverse of the last one, so no stale
//        value can pass for a fresh pixel
`timescale 1ns/1ns
module dsc_link_src (
  // clock
  input wire logic ref_clk,
  // link side
  input wire logic linkReady,
  output logic [dsc_pkg::WORD_W-1:0] linkWord,
  output logic linkValid,
  output logic linkCodeErr
);
  initial begin
    linkWord = 27'h000_0000;
    linkValid = 1'b0;
    linkCodeErr = 1'b0;
  end

  // one word is one pixel; the host owns bit order and gp bits
  task automatic send(input logic [26:0] w, input logic e);
    logic r;
    @(posedge ref_clk);
    #1;
    linkWord = w;
    linkCodeErr = e;
    linkValid = 1'b1;
    r = 1'b0;
    // ready sampled mid-cycle; inputs are stable up to the edge
    while (!r) begin
      @(negedge ref_clk);
      r = linkReady;
      @(posedge ref_clk);
    end
    #1;
    linkValid = 1'b0;
    linkCodeErr = 1'b0;
    linkWord = ~w;
  endtask : send
endmodule : dsc_link_src

// ===== testbench/tb.sv
// Purpose: self-checking bench for the receiver feature and payload block
// Assumes: lock count shortened to 4 words; clkEn held high except during the enable test
// Notes: random pixels from a fixed seed, corner cases written by hand
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
  n_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
  end end
module tb;
  localparam int LW = 4;
  logic ref_clk, rst, clkEn, regWrEn, regRdEn, strapEqOn;
  logic lowFreqSelect, colorDepth18, dispReady, rndRdy;
  logic [7:0] regAddr, regWrData, regRdData, d, v;
  logic [2:0] strapEqGain, strapSsc, equalizerGain;
  logic [26:0] linkWord, w, h;
  logic linkValid, linkCodeErr, linkReady;
  logic [23:0] dispColor;
  logic dispHsync, dispVsync, dispDataEn, dispValid;
  logic [5:0] dispGp;
  logic equalizerOn, sscActive, sscModTick, rxLocked;
  logic [11:0] sscModDiv;
  int n_errors, check_count, seed, cyc, n, i;
  logic [26:0] expQ[$];

  dsc_deser_ctrl #(.LOCK_WORDS(LW), .FIFO_DEPTH(8)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .strapEqGain(strapEqGain),
    .strapEqOn(strapEqOn), .strapSsc(strapSsc),
    .lowFreqSelect(lowFreqSelect), .colorDepth18(colorDepth18),
    .linkWord(linkWord), .linkValid(linkValid),
    .linkCodeErr(linkCodeErr), .linkReady(linkReady),
    .dispColor(dispColor), .dispHsync(dispHsync), .dispVsync(dispVsync),
    .dispDataEn(dispDataEn), .dispGp(dispGp), .dispValid(dispValid),
    .dispReady(dispReady), .equalizerGain(equalizerGain),
    .equalizerOn(equalizerOn), .sscActive(sscActive),
    .sscModDiv(sscModDiv), .sscModTick(sscModTick), .rxLocked(rxLocked));

  dsc_link_src src_u (.ref_clk(ref_clk), .linkReady(linkReady),
    .linkWord(linkWord), .linkValid(linkValid), .linkCodeErr(linkCodeErr));

  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  // hang guard, well above the expected run of about a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      end_sim();
    end
  end

  // display sink stalls at random while rndRdy is set
  always @(posedge ref_clk) if (rndRdy) dispReady <= #1 1'($random(seed));

  // every pixel taken by the display is compared with the sent order
  always @(negedge ref_clk) begin
    if (dispValid === 1'b1 && dispReady === 1'b1) begin
      `CHK("queued", 1'b1, expQ.size() > 0)
      if (expQ.size() > 0) begin
        h = expQ.pop_front();
        `CHK("color", h[23:0], dispColor)
        `CHK("sync", h[26:24], {dispDataEn, dispVsync, dispHsync})
        `CHK("gp", colorDepth18 ? {h[17:16], h[9:8], h[1:0]} : 6'h00,
          dispGp)
      end
    end
  end

  // register write, an idle edge then one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(posedge ref_clk);
    #1;
    regAddr = a;
    regWrData = dt;
    regWrEn = 1'b1;
    @(posedge ref_clk);
    #1;
    regWrEn = 1'b0;
  endtask : wr

  // register read, data registered at the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] dt);
    @(posedge ref_clk);
    #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge ref_clk);
    #1;
    regRdEn = 1'b0;
    dt = regRdData;
  endtask : rd

  // expected modulation divider for a nonzero spread code
  function automatic logic [11:0] expDiv(logic [2:0] c, logic lf);
    if (lf) return (c >= 3'h5) ? 12'h0181 : 12'h0271;
    return (c >= 3'h5) ? 12'h0514 : 12'h0878;
  endfunction : expDiv

  task automatic drain();
    n = 0;
    while (expQ.size() > 0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("drained", 0, expQ.size())
  endtask : drain

  // main sequence
  initial begin
    seed = 32'h1a03;
    {rst, clkEn, regWrEn, regRdEn, rndRdy} = 5'h18;
    {regAddr, regWrData} = 16'h0000;
    {strapEqGain, strapEqOn, strapSsc} = 7'h00;
    {lowFreqSelect, colorDepth18, dispReady} = 3'h1;
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    rd(8'h03, d);
    `CHK("feat reset", 8'h00, d)
    rd(8'h07, d);
    `CHK("unmapped", 8'h00, d)
    `CHK("lock reset", 1'b0, rxLocked)
    $display("test reset done");
    // pins rule until the register source bit is set
    {strapEqGain, strapEqOn, strapSsc} = 7'($random(seed));
    wr(8'h03, 8'hF5);
    `CHK("pin gain", strapEqGain, equalizerGain)
    `CHK("pin eq", strapEqOn, equalizerOn)
    `CHK("pin ssc", strapSsc != 3'h0, sscActive)
    wr(8'h00, 8'h01);
    `CHK("reg gain", 3'h7, equalizerGain)
    $display("test source done");
    // every gain, spread code and mode, bit 3 at random
    for (i = 0; i < 16; i++) begin
      lowFreqSelect = i[0];
      v = {i[2:0], i[3], 1'($random(seed)), i[3:1]};
      wr(8'h03, v);
      `CHK("gain", v[7:5], equalizerGain)
      `CHK("eq on", v[4], equalizerOn)
      `CHK("ssc on", v[2:0] != 3'h0, sscActive)
      if (v[2:0] != 3'h0) `CHK("div", expDiv(v[2:0], i[0]), sscModDiv)
      rd(8'h03, d);
      `CHK("readback", v, d)
    end
    $display("test decode done");
    // a write while the enable is low must not land
    clkEn = 1'b0;
    wr(8'h03, ~v);
    clkEn = 1'b1;
    rd(8'h03, d);
    `CHK("frozen", v, d)
    $display("test enable done");
    // tick spacing at the fastest rate
    lowFreqSelect = 1'b1;
    wr(8'h03, 8'h0D);
    n = 0;
    while (sscModTick !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (sscModTick !== 1'b1 && n < 1000);
    `CHK("tick gap", 385, n)
    $display("test tick done");
    // an error word restarts the clean run
    repeat (2) src_u.send(27'($random(seed)), 1'b0);
    src_u.send(27'($random(seed)), 1'b1);
    repeat (LW - 1) src_u.send(27'($random(seed)), 1'b0);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("no lock", 1'b0, rxLocked)
    src_u.send(27'($random(seed)), 1'b0);
    @(posedge ref_clk);
    #1;
    `CHK("locked", 1'b1, rxLocked)
    $display("test lock done");
    // random pixels with a stalling display
    rndRdy = 1'b1;
    repeat (24) begin
      w = 27'($random(seed));
      colorDepth18 = 1'($random(seed));
      expQ.push_back(w);
      src_u.send(w, 1'b0);
    end
    drain();
    $display("test stream done");
    // fill until refused, then drain to empty
    rndRdy = 1'b0;
    @(posedge ref_clk);
    #1 dispReady = 1'b0;
    repeat (8) begin
      w = 27'($random(seed));
      expQ.push_back(w);
      src_u.send(w, 1'b0);
    end
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("full", 1'b0, linkReady)
    dispReady = 1'b1;
    drain();
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("empty", 1'b0, dispValid)
    $display("test fifo done");
    // a bad word while locked drops lock and is not delivered
    src_u.send(27'($random(seed)), 1'b1);
    @(posedge ref_clk);
    #1;
    `CHK("lock lost", 1'b0, rxLocked)
    `CHK("hunt ready", 1'b1, linkReady)
    `CHK("dropped", 1'b0, dispValid)
    $display("test error done");
    end_sim();
  end
endmodule : tb
